/* File: src/psr_pkg.sv */
// package for the pseudo-static ram host controller: timing figures and states
// assumes a 100 MHz ref_clk; all device timing is counted in whole clock periods
// Notes on behaviour
// - chip enable low, same upper address, under 1000 ns
// - read address held at least read cycle time
// - page mode: only A0..A2 change, cycle 20 ns
// - continued page read closed within 4 us
// - short write-to-read gap stretches next read access
// - write cycle without address change under 1000 ns
// - write cycle at least pulse plus recovery
// - write pulse from last falling strobe, 40 ns
// - recovery from first rising strobe, minimum zero
// - byte mask setup/hold referenced to enable edges
// - output enable low after 5 ns starts read
// - output enable high before write address valid
// - byte write pulses overlap at least 30 ns
// - write strobe high at least 7.5 ns
// - power-down enable low 10 ns before, 65 after
// - partial exit: chip enable high 1 us
// - chip enable high 12 ns between accesses
package psr_pkg;
    localparam int CLK_PERIOD_PS = 10000;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int PAGE_BITS = 3;
    // figures in picoseconds so that 7.5 ns stays exact
    localparam int READ_CYCLE_PS = 65000;
    localparam int PAGE_CYCLE_PS = 20000;
    localparam int WRITE_PULSE_PS = 40000;
    localparam int WRITE_GAP_PS = 12000;
    localparam int WE_HIGH_PS = 7500;
    localparam int CE_HIGH_PS = 12000;
    localparam int PD_SETUP_PS = 10000;
    localparam int PD_HOLD_PS = 65000;
    localparam int CYCLE_MAX_PS = 1000000;
    localparam int PAGE_CLOSE_PS = 4000000;
    localparam int SLEEP_EXIT_US = 300;
    localparam int PART_EXIT_US = 1;
    // minimums round up, maximums round down
    localparam int READ_CYC = (READ_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PAGE_CYC = (PAGE_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WPULSE_CYC = (WRITE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WGAP_CYC = (WRITE_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WEHI_CYC = (WE_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CEHI_CYC = (CE_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PDSU_CYC = (PD_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PDHO_CYC = (PD_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CMAX_CYC = CYCLE_MAX_PS / CLK_PERIOD_PS;
    localparam int PCLOSE_CYC = PAGE_CLOSE_PS / CLK_PERIOD_PS;
    localparam int SLEEP_EXIT_CYC = SLEEP_EXIT_US * 1000000 / CLK_PERIOD_PS;
    localparam int PART_EXIT_CYC = PART_EXIT_US * 1000000 / CLK_PERIOD_PS;
    localparam int CNT_W = 20;
    localparam logic [1:0] BYTE_RESET = 2'h3;
    typedef enum logic [3:0] {
        PSR_POWERUP, PSR_IDLE, PSR_RD, PSR_PAGE, PSR_WR, PSR_WREC,
        PSR_CE_HIGH, PSR_PD_SETUP, PSR_PD_HOLD, PSR_PD, PSR_EXIT
    } psr_state_t;
endpackage : psr_pkg

/* File: src/psr_sync.sv */
// three-stage synchroniser for pin inputs; a change counts when stages two and three agree
// assumes the input is asynchronous to ref_clk
`timescale 1ns/1ns
module psr_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    s1_reg[i]   <= 1'b0;
                    s2_reg[i]   <= 1'b0;
                    s3_reg[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else if (clk_en) begin
                    s1_reg[i] <= pin_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        sync_out[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
endmodule : psr_sync

/* File: src/psr_ctrl.sv */
// host controller for an asynchronous pseudo-static ram: reads, page reads,
// byte-masked writes, power-down entry and exit, power-up hold
// assumes requests come from logic on ref_clk; memory data bus returns asynchronously
`timescale 1ns/1ns
module psr_ctrl (
    input  wire logic                         ref_clk,
    input  wire logic                         nrst,
    input  wire logic                         clk_en,
    input  wire logic                         req_valid,
    input  wire logic                         req_write,
    input  wire logic                         req_page,
    input  wire logic [psr_pkg::ADDR_W-1:0]   req_addr,
    input  wire logic [psr_pkg::DATA_W-1:0]   req_wdata,
    input  wire logic [1:0]                   req_byte_en,
    input  wire logic                         pd_req,
    input  wire logic                         pd_sleep,
    output logic                              req_ready,
    output logic                              rd_valid,
    output logic [psr_pkg::DATA_W-1:0]        rd_data,
    output logic                              pd_active,
    output logic [psr_pkg::ADDR_W-1:0]        mem_addr,
    output logic                              primary_chip_enable_n,
    output logic                              power_down_enable,
    output logic                              mem_oe_n,
    output logic                              mem_we_n,
    output logic                              lower_byte_strobe_n,
    output logic                              upper_byte_strobe_n,
    input  wire logic [psr_pkg::DATA_W-1:0]   mem_dq_in,
    output logic [psr_pkg::DATA_W-1:0]        mem_dq_out,
    output logic                              mem_dq_oe
);
    psr_pkg::psr_state_t state_reg;
    logic [psr_pkg::CNT_W-1:0] cnt_reg;
    logic [psr_pkg::CNT_W-1:0] page_cnt_reg;
    logic [psr_pkg::CNT_W-1:0] gap_cnt_reg;
    logic                      sleep_exit_reg;
    logic [psr_pkg::DATA_W-1:0] dq_sync;
    logic                      page_ok;
    logic                      page_timeout;

    localparam logic [psr_pkg::CNT_W-1:0] C_READ = psr_pkg::CNT_W'(psr_pkg::READ_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_PAGE = psr_pkg::CNT_W'(psr_pkg::PAGE_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_WPUL = psr_pkg::CNT_W'(psr_pkg::WPULSE_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_WGAP = psr_pkg::CNT_W'(psr_pkg::WGAP_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_WEHI = psr_pkg::CNT_W'(psr_pkg::WEHI_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_CEHI = psr_pkg::CNT_W'(psr_pkg::CEHI_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_PDSU = psr_pkg::CNT_W'(psr_pkg::PDSU_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_PDHO = psr_pkg::CNT_W'(psr_pkg::PDHO_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_PCLS = psr_pkg::CNT_W'(
        (psr_pkg::CMAX_CYC < psr_pkg::PCLOSE_CYC) ? psr_pkg::CMAX_CYC : psr_pkg::PCLOSE_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_SLPX = psr_pkg::CNT_W'(psr_pkg::SLEEP_EXIT_CYC);
    localparam logic [psr_pkg::CNT_W-1:0] C_PRTX = psr_pkg::CNT_W'(psr_pkg::PART_EXIT_CYC);

    // read data is caught three flops after the access window closes
    psr_sync #(
        .W (psr_pkg::DATA_W)
    ) u_dq_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .pin_in   (mem_dq_in),
        .sync_out (dq_sync)
    );

    // page hit: same upper address, only the low bits may move
    assign page_ok = req_valid && !req_write && req_page && !pd_req &&
                     (req_addr[psr_pkg::ADDR_W-1:psr_pkg::PAGE_BITS] ==
                      mem_addr[psr_pkg::ADDR_W-1:psr_pkg::PAGE_BITS]);
    // leave margin for the next page cycle so the page closes in time
    assign page_timeout = (page_cnt_reg + C_PAGE + C_PAGE + 20'h00006) >= C_PCLS;

    // time since write strobe rose, so a following read never sees a short gap
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gap_cnt_reg <= '0;
        end else if (clk_en) begin
            if (state_reg == psr_pkg::PSR_WR) begin
                gap_cnt_reg <= '0;
            end else if (gap_cnt_reg < C_WGAP) begin
                gap_cnt_reg <= gap_cnt_reg + 20'h00001;
            end
        end
    end

    // page sequence age, restarted when chip enable falls for a read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            page_cnt_reg <= '0;
        end else if (clk_en) begin
            if (state_reg == psr_pkg::PSR_RD || state_reg == psr_pkg::PSR_PAGE) begin
                page_cnt_reg <= page_cnt_reg + 20'h00001;
            end else begin
                page_cnt_reg <= '0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg             <= psr_pkg::PSR_POWERUP;
            cnt_reg               <= '0;
            sleep_exit_reg        <= 1'b1;
            req_ready             <= 1'b0;
            rd_valid              <= 1'b0;
            rd_data               <= '0;
            pd_active             <= 1'b0;
            mem_addr              <= '0;
            primary_chip_enable_n <= 1'b1;
            power_down_enable     <= 1'b1;
            mem_oe_n              <= 1'b1;
            mem_we_n              <= 1'b1;
            lower_byte_strobe_n   <= 1'b1;
            upper_byte_strobe_n   <= 1'b1;
            mem_dq_out            <= '0;
            mem_dq_oe             <= 1'b0;
        end else if (clk_en) begin
            rd_valid  <= 1'b0;
            req_ready <= 1'b0;
            cnt_reg   <= cnt_reg + 20'h00001;
            case (state_reg)
                psr_pkg::PSR_POWERUP: begin
                    // power-up counts as sleep exit: enable held high 300 us
                    if (cnt_reg >= C_SLPX) begin
                        state_reg <= psr_pkg::PSR_IDLE;
                        req_ready <= 1'b1;
                        cnt_reg   <= '0;
                    end
                end
                psr_pkg::PSR_IDLE: begin
                    req_ready <= 1'b1;
                    if (pd_req) begin
                        req_ready      <= 1'b0;
                        sleep_exit_reg <= pd_sleep;
                        power_down_enable <= 1'b0;
                        state_reg      <= psr_pkg::PSR_PD_SETUP;
                        cnt_reg        <= '0;
                    end else if (req_valid && req_write && gap_cnt_reg >= C_WGAP) begin
                        // oe already high before the address moves
                        req_ready             <= 1'b0;
                        mem_addr              <= req_addr;
                        mem_dq_out            <= req_wdata;
                        mem_dq_oe             <= 1'b1;
                        primary_chip_enable_n <= 1'b0;
                        mem_we_n              <= 1'b0;
                        // masked lanes stay high through the whole pulse
                        lower_byte_strobe_n   <= !req_byte_en[0];
                        upper_byte_strobe_n   <= !req_byte_en[1];
                        state_reg             <= psr_pkg::PSR_WR;
                        cnt_reg               <= '0;
                    end else if (req_valid && !req_write && gap_cnt_reg >= C_WGAP) begin
                        req_ready             <= 1'b0;
                        mem_addr              <= req_addr;
                        primary_chip_enable_n <= 1'b0;
                        mem_oe_n              <= 1'b0;
                        lower_byte_strobe_n   <= 1'b0;
                        upper_byte_strobe_n   <= 1'b0;
                        state_reg             <= psr_pkg::PSR_RD;
                        cnt_reg               <= '0;
                    end else if (req_valid) begin
                        req_ready <= 1'b0;
                    end
                end
                psr_pkg::PSR_RD: begin
                    // read cycle, then three edges for the data synchroniser
                    if (cnt_reg >= C_READ + 20'h00003) begin
                        rd_data  <= dq_sync;
                        rd_valid <= 1'b1;
                        if (page_ok && !page_timeout) begin
                            mem_addr  <= req_addr;
                            req_ready <= 1'b1;
                            state_reg <= psr_pkg::PSR_PAGE;
                        end else begin
                            primary_chip_enable_n <= 1'b1;
                            mem_oe_n              <= 1'b1;
                            lower_byte_strobe_n   <= 1'b1;
                            upper_byte_strobe_n   <= 1'b1;
                            state_reg             <= psr_pkg::PSR_CE_HIGH;
                        end
                        cnt_reg <= '0;
                    end
                end
                psr_pkg::PSR_PAGE: begin
                    // page access, one settled sample, three synchroniser edges
                    if (cnt_reg >= C_PAGE + 20'h00004) begin
                        rd_data  <= dq_sync;
                        rd_valid <= 1'b1;
                        cnt_reg  <= '0;
                        if (page_ok && !page_timeout) begin
                            mem_addr  <= req_addr;
                            req_ready <= 1'b1;
                        end else begin
                            primary_chip_enable_n <= 1'b1;
                            mem_oe_n              <= 1'b1;
                            lower_byte_strobe_n   <= 1'b1;
                            upper_byte_strobe_n   <= 1'b1;
                            state_reg             <= psr_pkg::PSR_CE_HIGH;
                        end
                    end
                end
                psr_pkg::PSR_WR: begin
                    // pulse starts when the last strobe falls, held 70 ns, over the 40 ns minimum
                    // the write cycle also covers the read cycle time
                    if (cnt_reg >= C_WPUL && cnt_reg >= C_READ - C_WEHI) begin
                        // all strobes rise together, recovery starts here
                        primary_chip_enable_n <= 1'b1;
                        mem_we_n              <= 1'b1;
                        lower_byte_strobe_n   <= 1'b1;
                        upper_byte_strobe_n   <= 1'b1;
                        state_reg             <= psr_pkg::PSR_WREC;
                        cnt_reg               <= '0;
                    end
                end
                psr_pkg::PSR_WREC: begin
                    // data held one cycle past the rising strobes; zero hold suffices
                    mem_dq_oe <= 1'b0;
                    state_reg <= psr_pkg::PSR_CE_HIGH;
                    cnt_reg   <= 20'h00001;
                end
                psr_pkg::PSR_CE_HIGH: begin
                    // enable and write strobe both stay high long enough
                    if (cnt_reg + 20'h00001 >= C_CEHI && cnt_reg + 20'h00001 >= C_WEHI) begin
                        state_reg <= psr_pkg::PSR_IDLE;
                        req_ready <= 1'b1;
                        cnt_reg   <= '0;
                    end
                end
                psr_pkg::PSR_PD_SETUP: begin
                    // setup before the entry point, chip enable high all along
                    if (cnt_reg + 20'h00001 >= C_PDSU) begin
                        state_reg <= psr_pkg::PSR_PD_HOLD;
                        cnt_reg   <= '0;
                    end
                end
                psr_pkg::PSR_PD_HOLD: begin
                    if (cnt_reg + 20'h00001 >= C_PDHO) begin
                        pd_active <= 1'b1;
                        state_reg <= psr_pkg::PSR_PD;
                        cnt_reg   <= '0;
                    end
                end
                psr_pkg::PSR_PD: begin
                    if (!pd_req) begin
                        power_down_enable <= 1'b1;
                        state_reg         <= psr_pkg::PSR_EXIT;
                        cnt_reg           <= '0;
                    end
                end
                psr_pkg::PSR_EXIT: begin
                    // sleep needs the long hold, partial modes the short one
                    if ((sleep_exit_reg && cnt_reg + 20'h00001 >= C_SLPX) ||
                        (!sleep_exit_reg && cnt_reg + 20'h00001 >= C_PRTX)) begin
                        pd_active <= 1'b0;
                        req_ready <= 1'b1;
                        state_reg <= psr_pkg::PSR_IDLE;
                        cnt_reg   <= '0;
                    end
                end
                default: begin
                    state_reg <= psr_pkg::PSR_IDLE;
                    cnt_reg   <= '0;
                end
            endcase
        end
    end
endmodule : psr_ctrl

/* File: tb/psr_ctrl_checker.sv */
// pin timing checker for psr_ctrl
// assumes it is bound into psr_ctrl and sees only that module's ports
`timescale 1ns/1ns
module psr_ctrl_checker (
    input wire logic                       ref_clk,
    input wire logic                       nrst,
    input wire logic                       pd_sleep,
    input wire logic [psr_pkg::ADDR_W-1:0] mem_addr,
    input wire logic                       primary_chip_enable_n,
    input wire logic                       power_down_enable,
    input wire logic                       mem_oe_n,
    input wire logic                       mem_we_n,
    input wire logic                       mem_dq_oe
);
    localparam int SLP = psr_pkg::SLEEP_EXIT_CYC - 1;
    localparam int PRT = psr_pkg::PART_EXIT_CYC - 1;
    wire         sel_n = primary_chip_enable_n;
    wire         pwr   = power_down_enable;
    logic [19:0] hold_reg;
    logic        sleep_reg;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // high cycles since power returned; never cleared by accesses, so later falls pass
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hold_reg  <= '0;
            sleep_reg <= 1'h1;
        end else if (!pwr) begin
            hold_reg  <= '0;
            sleep_reg <= pd_sleep;
        end else if (sel_n && hold_reg != 20'hfffff) hold_reg <= hold_reg + 20'h1;
    end
    sequence s_rd_start; $fell(sel_n) && !mem_oe_n; endsequence
    sequence s_wr_pulse; (!mem_we_n && !sel_n)[*4]; endsequence
    property p_ce_gap; $rose(sel_n) |-> sel_n[*2]; endproperty
    property p_wr_pulse; $fell(mem_we_n) |-> s_wr_pulse; endproperty
    property p_rd_no_wr; s_rd_start |-> mem_we_n[*7]; endproperty
    property p_oe_write; (!mem_we_n || mem_dq_oe) |-> mem_oe_n; endproperty
    property p_addr_hold; $fell(sel_n) |=> $stable(mem_addr)[*6]; endproperty
    property p_page_upper; !sel_n && !$fell(sel_n) |-> $stable(mem_addr[20:3]); endproperty
    property p_pd_entry; $fell(pwr) |-> $past(sel_n) ##0 (!pwr && sel_n)[*7]; endproperty
    property p_exit_hold; $fell(sel_n) |-> hold_reg >= (sleep_reg ? SLP : PRT); endproperty
    a_ce_gap: assert property (p_ce_gap) else $error("enable high gap short");
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse short");
    a_rd_no_wr: assert property (p_rd_no_wr) else $error("write inside read cycle");
    a_oe_write: assert property (p_oe_write) else $error("output enable low in write");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved early");
    a_page_upper: assert property (p_page_upper) else $error("upper address moved");
    a_pd_entry: assert property (p_pd_entry) else $error("power-down entry timing");
    a_exit_hold: assert property (p_exit_hold) else $error("exit hold short");
endmodule : psr_ctrl_checker

/* File: tb/psr_mem_model.sv */
// behavioural pseudo-static ram answering the controller's pins
// assumes pin changes land at odd ns; sampling every 2 ns keeps clear of those edges
`timescale 1ns/1ns
module psr_mem_model (
    input  wire logic [20:0] mem_addr,
    input  wire logic        sel_n,
    input  wire logic        pwr,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        byte_lo_n,
    input  wire logic        byte_hi_n,
    input  wire logic [15:0] dq_wr,
    output logic      [15:0] dq_rd,
    output int               viol
);
    logic [15:0] mem [logic [20:0]];
    logic [20:0] a_q = '0, wa;
    logic [15:0] wd, old;
    logic [1:0]  wl;
    logic        sel_q = 1'h1, oe_q = 1'h1, wr_on = 1'h0;
    time         t_acc = 0, t_wr = 0, t_we_up = 0, t_sel_up = 0, t_pwr_up = 0, need = 300000;
    time         write_to_read_gap;
    initial viol = 0;
    initial dq_rd = 16'h5a5a;
    function automatic time full_acc();
        write_to_read_gap = $time - t_we_up;
        return $time + 65 + ((write_to_read_gap < 12) ? 12 - write_to_read_gap : 0);
    endfunction
    always @(posedge pwr) begin
        t_pwr_up = $time;
        need = ($time < 100) ? 300000 : 1000;
    end
    always @(posedge sel_n) t_sel_up = $time;
    always @(negedge sel_n) begin
        if (!pwr || $time - t_pwr_up < need || $time - t_sel_up < 12) viol++;
    end
    always #2 begin
        if (!sel_n && !sel_q && a_q != mem_addr && ($time < t_acc || a_q[20:3] != mem_addr[20:3]))
            viol++;
        if ((!sel_n && sel_q) || (!oe_n && oe_q) || a_q[20:3] != mem_addr[20:3])
            t_acc = full_acc();
        else if (a_q != mem_addr) t_acc = $time + 20;
        if (pwr && !sel_n && !we_n && !(byte_lo_n && byte_hi_n)) begin
            if (!wr_on) t_wr = $time;
            if (!oe_n) viol++;
            wr_on = 1'h1;
            wa = mem_addr;
            wd = dq_wr;
            wl = ~{byte_hi_n, byte_lo_n};
        end else if (wr_on) begin
            wr_on = 1'h0;
            t_we_up = $time;
            if ($time - t_wr < 40) viol++;
            old = mem.exists(wa) ? mem[wa] : 16'h0;
            mem[wa] = {wl[1] ? wd[15:8] : old[15:8], wl[0] ? wd[7:0] : old[7:0]};
        end
        if (pwr && !sel_n && !oe_n && we_n && $time >= t_acc && mem.exists(mem_addr))
            dq_rd = mem[mem_addr];
        else
            dq_rd = ~dq_rd; // bus toggles until valid, so a stale sample never matches
        sel_q = sel_n;
        oe_q = oe_n;
        a_q = mem_addr;
    end
endmodule : psr_mem_model

/* File: tb/psr_ctrl_tb.sv */
// top testbench: psr_ctrl driving the behavioural memory model
// assumes the 300 us power-up hold is run in full, so the run is just over 60k cycles
`timescale 1ns/1ns
module psr_ctrl_tb;
    logic        ref_clk = 1'h0, nrst = 1'h0, req_valid = 1'h0, req_write = 1'h0;
    logic        req_page = 1'h0, pd_req = 1'h0, pd_sleep = 1'h0;
    logic [20:0] req_addr = '0, mem_addr;
    logic [15:0] req_wdata = '0, mem_dq_in, mem_dq_out, rd_data;
    logic [1:0]  req_byte_en = 2'h3;
    logic        req_ready, rd_valid, pd_active, primary_chip_enable_n, power_down_enable;
    logic        mem_oe_n, mem_we_n, lower_byte_strobe_n, upper_byte_strobe_n, mem_dq_oe;
    int          n_errors = 0, checks = 0, cyc = 0, viol;
    psr_ctrl u_psr_ctrl (.ref_clk, .nrst, .clk_en(1'h1), .req_valid, .req_write, .req_page,
        .req_addr, .req_wdata, .req_byte_en, .pd_req, .pd_sleep, .req_ready, .rd_valid, .rd_data,
        .pd_active, .mem_addr, .primary_chip_enable_n, .power_down_enable, .mem_oe_n, .mem_we_n,
        .lower_byte_strobe_n, .upper_byte_strobe_n, .mem_dq_in, .mem_dq_out, .mem_dq_oe);
    psr_mem_model u_psr_mem_model (.mem_addr, .sel_n(primary_chip_enable_n),
        .pwr(power_down_enable), .oe_n(mem_oe_n), .we_n(mem_we_n), .byte_lo_n(lower_byte_strobe_n),
        .byte_hi_n(upper_byte_strobe_n), .dq_wr(mem_dq_out), .dq_rd(mem_dq_in), .viol);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp);
        check_word({15'h0, got}, {15'h0, exp});
    endtask : check_bit
    // held until an edge sees the controller idle, released 1 ns after that edge, then one more edge
    task automatic issue(input logic wr, input logic [20:0] a, input logic [15:0] d,
                         input logic [1:0] be);
        int n;
        n = 0;
        req_valid = 1'h1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_byte_en = be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'h1 && n < 40000);
        #1;
        req_valid = 1'h0;
        check_bit(n < 40000, 1'h1);
        step(1);
    endtask : issue
    task automatic read_word(input logic [20:0] a, input logic [15:0] exp);
        int n;
        n = 0;
        issue(1'h0, a, 16'h0, 2'h3);
        while (rd_valid !== 1'h1 && n < 20) begin
            step(1);
            n++;
        end
        check_word(rd_data, exp);
    endtask : read_word
    task automatic t_powerup();
        check_bit(primary_chip_enable_n, 1'h1);
        check_bit(power_down_enable, 1'h1);
        nrst = 1'h1;
        step(29900);
        check_bit(req_ready, 1'h0);
        step(200);
        check_bit(req_ready, 1'h1);
    endtask : t_powerup
    task automatic t_write_read();
        issue(1'h1, 21'h012345, 16'ha5c3, 2'h3);
        issue(1'h1, 21'h1ffff8, 16'h3c5a, 2'h3);
        read_word(21'h012345, 16'ha5c3);
        read_word(21'h1ffff8, 16'h3c5a);
    endtask : t_write_read
    task automatic t_bytes();
        issue(1'h1, 21'h000400, 16'h1111, 2'h3);
        issue(1'h1, 21'h000400, 16'h22ee, 2'h1);
        issue(1'h1, 21'h000400, 16'h77bb, 2'h2);
        read_word(21'h000400, 16'h77ee);
    endtask : t_bytes
    // page words are read in descending order, so A0 and A1 move both ways and A2 only falls
    task automatic t_page();
        int i;
        int n;
        for (i = 0; i < 8; i++) issue(1'h1, 21'h0a0a8 + 21'(i), 16'h0100 + 16'(i), 2'h3);
        req_valid = 1'h1;
        req_page = 1'h1;
        req_write = 1'h0;
        req_addr = 21'h0a0af;
        // each page address must stand before the slot that takes it ends
        do @(posedge ref_clk); while (req_ready !== 1'h1);
        #1;
        for (i = 0; i < 8; i++) begin
            req_addr = 21'h0a0a8 + 21'(6 - i);
            req_valid = (i < 7);
            n = 0;
            step(1);
            while (rd_valid !== 1'h1 && n < 20) begin
                step(1);
                n++;
            end
            check_word(rd_data, 16'h0100 + 16'(7 - i));
        end
        req_valid = 1'h0;
        req_page = 1'h0;
        step(2);
    endtask : t_page
    task automatic t_pd(input logic sl, input int hold);
        int n;
        n = 0;
        pd_sleep = sl;
        pd_req = 1'h1;
        while (pd_active !== 1'h1 && n < 100) begin
            step(1);
            n++;
        end
        check_bit(power_down_enable, 1'h0);
        check_bit(primary_chip_enable_n, 1'h1);
        pd_req = 1'h0;
        n = 0;
        while (pd_active !== 1'h0 && n < 31000) begin
            step(1);
            n++;
        end
        check_bit(n >= hold, 1'h1);
        issue(1'h1, 21'h000777, 16'h9e01, 2'h3);
        read_word(21'h000777, 16'h9e01);
    endtask : t_pd
    initial begin
        step(16);
        t_powerup();
        t_write_read();
        t_bytes();
        t_page();
        t_pd(1'h0, psr_pkg::PART_EXIT_CYC);
        t_pd(1'h1, psr_pkg::SLEEP_EXIT_CYC);
        check_word(16'(viol), 16'h0);
        print_verdict();
    end
endmodule : psr_ctrl_tb
bind psr_ctrl psr_ctrl_checker u_psr_ctrl_checker (.ref_clk, .nrst, .pd_sleep, .mem_addr,
    .primary_chip_enable_n, .power_down_enable, .mem_oe_n, .mem_we_n, .mem_dq_oe);
